// [design/lpmc_pkg.sv]
/*
 Shared constants and carriers for the low-power mode controller.
 Assumes one 200 MHz clock and an APB master for the register port.
*/
package lpmc_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] HALT_OPCODE = 8'h8e;
  localparam logic [1:0] MASK_WAKE = 2'h2;
  localparam int STAB_SHORT = 256;
  localparam int STAB_LONG = 4096;
  // APB map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PORT_VAL = 12'h008;
  localparam logic [11:0] ADDR_PORT_DIR = 12'h00c;
  localparam logic [11:0] ADDR_PORT_OPT = 12'h010;
  // Control field positions
  localparam int CTRL_OIE = 0;
  localparam int CTRL_SLOW = 1;
  localparam int CTRL_LONG = 2;
  localparam int CTRL_WDG_HALT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Wakeup source bits
  localparam int SRC_TIMEBASE = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_EXT3 = 4;
  localparam int SRC_SPI = 5;
  localparam int SRC_TIMER_A = 6;
  localparam int SRC_TIMER_B = 7;
  localparam int SRC_SERIAL = 8;
  localparam int SRC_VOLT = 9;
  localparam logic [9:0] HALT_WAKE_MASK = 10'h03e;
  localparam logic [9:0] AHALT_WAKE_MASK = 10'h03f;

  typedef enum logic [2:0] {
    LPMC_RUN = 3'b000,
    LPMC_WAIT = 3'b001,
    LPMC_AHALT = 3'b010,
    LPMC_HALT = 3'b011,
    LPMC_STAB = 3'b100
  } lpmc_mode_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic slow_wait;
    logic force_mask;
    logic wdg_reset;
    logic resume;
    logic reset_fetch;
  } lpmc_out_t;
endpackage : lpmc_pkg

// [design/lpmc_top.sv]
/*
 Low-power mode controller: run, wait, active-halt and halt sequencing,
 wakeup filtering, stabilisation delay and one 8-pin port register set.
 Assumes the CPU pulses wait/halt decode, and a soft reset request
 stands separately from presetn, which clears everything.
*/
// Design decisions made here: the register offsets and register access over APB.
// Function
// - Wait instruction stops CPU, peripherals run
// - Wait forces interrupt mask to 10
// - Wait leaves other state unaltered
// - Wait ends on interrupt or reset
// - Service pushes mask, pop restores it
// - Halt picks halt or active-halt by enable
// - Active-halt wakes on interrupt without delay
// - Reset from active-halt waits stabilisation
// - Halt modes force mask; pending wakes at once
// - Active-halt keeps only oscillator and timebase
// - Active-halt with enable blocks watchdog reset
// - Early enable clear falls into halt
// - Delay is 256 or 4096 by option
// - Halt wakes on interrupt, waits stabilisation
// - Halt switches oscillator off
// - Watchdog option turns halt into reset
// - Opcode 8e decodes as halt
// - Port holds eight configurable pins
// - Bit X controls pin X
// - Only listed sources wake halt modes
// - Wait while slow gives slow-wait
`timescale 1ns/100ps
module lpmc_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic wait_instruction,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [9:0] irq_pending,
  input wire logic reset_request,
  input wire logic watchdog_enabled,
  input wire logic [1:0] condition_code_mask,
  // Mode outputs
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic slow_wait,
  output logic force_mask,
  output logic [1:0] forced_mask_value,
  output logic wdg_reset,
  output logic resume,
  output logic reset_fetch,
  output logic [2:0] mode,
  // Port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_irq
);

  typedef struct packed {
    lpmc_pkg::lpmc_mode_t st;
    logic [12:0] cnt;
    logic stab_for_reset;
    logic ahalt_woke;
    logic [12:0] grace;
    logic [31:0] ctrl;
    logic [7:0] port_val;
    logic [7:0] port_dir;
    logic [7:0] port_opt;
    logic [31:0] rdata;
    logic ready;
    logic err;
    lpmc_pkg::lpmc_out_t o;
    logic [7:0] irq;
    logic [7:0] pin_q;
  } lpmc_state_t;

  lpmc_state_t cur;
  lpmc_state_t next_s;

  logic halt_dec;
  logic [12:0] stab_len;
  logic wake_ahalt;
  logic wake_halt;
  logic setup;
  logic [12:0] grace_cnt;

  assign halt_dec = opcode_valid && (opcode == lpmc_pkg::HALT_OPCODE);
  assign stab_len = cur.ctrl[lpmc_pkg::CTRL_LONG] ?
    13'(lpmc_pkg::STAB_LONG) : 13'(lpmc_pkg::STAB_SHORT);
  assign wake_ahalt = |(irq_pending & lpmc_pkg::AHALT_WAKE_MASK);
  assign wake_halt = |(irq_pending & lpmc_pkg::HALT_WAKE_MASK);
  assign setup = psel && !penable;
  assign grace_cnt = cur.grace;

  always_comb begin
    next_s = cur;
    next_s.o.resume = 1'b0;
    next_s.o.reset_fetch = 1'b0;
    next_s.o.wdg_reset = 1'b0;
    next_s.ready = 1'b0;
    next_s.err = 1'b0;
    next_s.pin_q = pin_in;
    if (cur.grace != 13'h0) begin
      next_s.grace = cur.grace - 13'h1;
    end
    // Pin input, interrupt-capable when input with option set
    next_s.irq = ~cur.port_dir & cur.port_opt & ~pin_in & cur.pin_q;
    unique case (cur.st)
      lpmc_pkg::LPMC_RUN: begin
        if (reset_request) begin
          next_s.o.reset_fetch = 1'b1;
        end else if (wait_instruction) begin
          next_s.st = lpmc_pkg::LPMC_WAIT;
        end else if (halt_dec) begin
          if (cur.ctrl[lpmc_pkg::CTRL_OIE]) begin
            next_s.st = lpmc_pkg::LPMC_AHALT;
          end else if (watchdog_enabled &&
                       cur.ctrl[lpmc_pkg::CTRL_WDG_HALT]) begin
            next_s.o.wdg_reset = 1'b1;
          end else begin
            next_s.st = lpmc_pkg::LPMC_HALT;
          end
        end else if (cur.grace != 13'h0 &&
                     !cur.ctrl[lpmc_pkg::CTRL_OIE]) begin
          // Enable cleared too early after active-halt wakeup
          next_s.st = lpmc_pkg::LPMC_HALT;
          next_s.cnt = cur.grace;
        end
      end
      lpmc_pkg::LPMC_WAIT: begin
        if (reset_request) begin
          next_s.st = lpmc_pkg::LPMC_RUN;
          next_s.o.reset_fetch = 1'b1;
        end else if (|irq_pending) begin
          next_s.st = lpmc_pkg::LPMC_RUN;
          next_s.o.resume = 1'b1;
        end
      end
      lpmc_pkg::LPMC_AHALT: begin
        if (reset_request) begin
          next_s.st = lpmc_pkg::LPMC_STAB;
          next_s.stab_for_reset = 1'b1;
          next_s.cnt = stab_len;
        end else if (wake_ahalt) begin
          next_s.st = lpmc_pkg::LPMC_RUN;
          next_s.o.resume = 1'b1;
          next_s.grace = stab_len;
        end
      end
      lpmc_pkg::LPMC_HALT: begin
        if (reset_request || wake_halt) begin
          next_s.st = lpmc_pkg::LPMC_STAB;
          next_s.stab_for_reset = reset_request;
          if (cur.cnt == 13'h0) begin
            next_s.cnt = stab_len;
          end
        end
      end
      lpmc_pkg::LPMC_STAB: begin
        if (cur.cnt <= 13'h1) begin
          next_s.st = lpmc_pkg::LPMC_RUN;
          next_s.cnt = 13'h0;
          next_s.o.resume = !cur.stab_for_reset;
          next_s.o.reset_fetch = cur.stab_for_reset;
        end else begin
          next_s.cnt = cur.cnt - 13'h1;
        end
      end
      default: next_s.st = lpmc_pkg::LPMC_RUN;
    endcase
    // Clock gating follows the next mode so it lines up with it
    next_s.o.cpu_clk_en = (next_s.st == lpmc_pkg::LPMC_RUN);
    next_s.o.periph_clk_en = (next_s.st == lpmc_pkg::LPMC_RUN) ||
      (next_s.st == lpmc_pkg::LPMC_WAIT);
    // Oscillator restarts at once on halt wakeup, before the count
    next_s.o.osc_en = (next_s.st != lpmc_pkg::LPMC_HALT);
    next_s.o.slow_wait = (next_s.st == lpmc_pkg::LPMC_WAIT) &&
      cur.ctrl[lpmc_pkg::CTRL_SLOW];
    // Mask only forced; CPU keeps the rest of its state
    next_s.o.force_mask = (next_s.st != lpmc_pkg::LPMC_RUN);
    // APB access; one wait state, answers on second access cycle
    if (psel && penable && !cur.ready) begin
      next_s.ready = 1'b1;
      next_s.rdata = 32'h0;
      unique case (paddr)
        lpmc_pkg::ADDR_CTRL: begin
          if (pwrite) next_s.ctrl = {28'h0, pwdata[3:0]};
          next_s.rdata = cur.ctrl;
        end
        lpmc_pkg::ADDR_STATUS: begin
          next_s.rdata = {16'h0, 3'h0, grace_cnt};
          next_s.rdata[31:29] = cur.st;
        end
        lpmc_pkg::ADDR_PORT_VAL: begin
          if (pwrite) next_s.port_val = pwdata[7:0];
          // Input pins read the pin, output pins the latch
          next_s.rdata = {24'h0, (cur.port_dir & cur.port_val) |
                          (~cur.port_dir & cur.pin_q)};
        end
        lpmc_pkg::ADDR_PORT_DIR: begin
          if (pwrite) next_s.port_dir = pwdata[7:0];
          next_s.rdata = {24'h0, cur.port_dir};
        end
        lpmc_pkg::ADDR_PORT_OPT: begin
          if (pwrite) next_s.port_opt = pwdata[7:0];
          next_s.rdata = {24'h0, cur.port_opt};
        end
        default: next_s.err = 1'b1;
      endcase
    end else if (setup) begin
      next_s.rdata = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{st: lpmc_pkg::LPMC_RUN, cnt: 13'h0, stab_for_reset: 1'b0,
               ahalt_woke: 1'b0, grace: 13'h0,
               ctrl: lpmc_pkg::CTRL_RESET, port_val: 8'h00,
               port_dir: 8'h00, port_opt: 8'h00, rdata: 32'h0,
               ready: 1'b0, err: 1'b0,
               o: '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                    default: 1'b0},
               irq: 8'h00, pin_q: 8'h00};
    end else begin
      cur <= next_s;
    end
  end

  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;
  assign cpu_clk_en = cur.o.cpu_clk_en;
  assign periph_clk_en = cur.o.periph_clk_en;
  assign osc_en = cur.o.osc_en;
  assign slow_wait = cur.o.slow_wait;
  assign force_mask = cur.o.force_mask;
  assign forced_mask_value = lpmc_pkg::MASK_WAKE;
  assign wdg_reset = cur.o.wdg_reset;
  assign resume = cur.o.resume;
  assign reset_fetch = cur.o.reset_fetch;
  assign mode = cur.st;
  assign pin_out = cur.port_val;
  assign pin_oe = cur.port_dir;
  assign pin_irq = cur.irq;

  // Push/pop of the mask on service stays in the CPU; this block only
  // releases its forcing once running so the pushed value is intact.

  sequence s_wait_enter;
    cur.st == lpmc_pkg::LPMC_RUN && wait_instruction && !reset_request;
  endsequence

  AST_WAIT_GATES: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_enter |=> !cpu_clk_en && periph_clk_en && force_mask)
    else $error("wait entry did not gate cpu only");
  AST_MASK_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    force_mask |-> forced_mask_value == 2'h2)
    else $error("forced mask not 10");
  AST_WAIT_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_WAIT && |irq_pending && !reset_request
    |=> resume && cpu_clk_en)
    else $error("wait did not end on interrupt");
  AST_HALT_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_RUN && halt_dec && !wait_instruction &&
    !reset_request && cur.ctrl[0] |=> mode == 3'b010)
    else $error("halt with enable did not enter active-halt");
  AST_AHALT_FAST: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_AHALT && !reset_request && wake_ahalt
    |=> resume ##0 cpu_clk_en)
    else $error("active-halt wake was delayed");
  AST_HALT_OSC: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 3'b011 |-> !osc_en && !periph_clk_en)
    else $error("oscillator running in halt");
  AST_STAB_256: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_HALT && wake_halt && !reset_request &&
    cur.cnt == 13'h0 && !cur.ctrl[2]
    |=> !resume [*8] ##[240:260] resume)
    else $error("halt wake did not wait stabilisation");
  AST_WDG_OPT: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_RUN && halt_dec && !wait_instruction &&
    !reset_request && !cur.ctrl[0] && watchdog_enabled && cur.ctrl[3]
    |=> wdg_reset && mode == 3'b000)
    else $error("watchdog option did not reset");
  AST_AHALT_NO_WDG: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_AHALT |-> !cur.o.wdg_reset)
    else $error("watchdog reset in active-halt");
  AST_SLOW_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_RUN && wait_instruction && !reset_request &&
    cur.ctrl[1] |=> slow_wait)
    else $error("slow-wait not flagged");

  sequence s_halt_wake;
    cur.st == lpmc_pkg::LPMC_HALT && wake_halt && !reset_request &&
    cur.cnt == 13'h0;
  endsequence

  sequence s_stab_done;
    cur.st == lpmc_pkg::LPMC_STAB && cur.cnt <= 13'h1;
  endsequence

  AST_WAIT_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_enter ##0 !(psel && penable) |=> $stable(cur.ctrl))
    else $error("wait entry altered control state");
  AST_WAIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_WAIT && !reset_request && !(|irq_pending)
    |=> mode == 3'h1)
    else $error("wait left without interrupt or reset");
  AST_WAIT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_WAIT && reset_request
    |=> reset_fetch && mode == 3'h0)
    else $error("wait did not end on reset");
  AST_WAIT_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 3'h1 |-> periph_clk_en && !cpu_clk_en && osc_en)
    else $error("wait clocks wrong");
  AST_RUN_UNMASK: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 3'h0 |-> !force_mask)
    else $error("mask still forced while running");
  AST_HALT_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 3'h2 || mode == 3'h3 |-> force_mask)
    else $error("halt modes did not force mask");
  AST_AHALT_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    mode == 3'h2 |-> osc_en && !periph_clk_en && !cpu_clk_en)
    else $error("active-halt clocks wrong");
  AST_AHALT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_AHALT && reset_request
    |=> mode == 3'h4 && !reset_fetch)
    else $error("active-halt reset skipped stabilisation");
  AST_AHALT_STAY: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_AHALT && !reset_request && !wake_ahalt
    |=> mode == 3'h2)
    else $error("active-halt left on a non-wake source");
  AST_HALT_STAY: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_HALT && !reset_request && !wake_halt
    |=> mode == 3'h3)
    else $error("halt left on a non-wake source");
  AST_HALT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_HALT && reset_request
    |=> mode == 3'h4 && osc_en)
    else $error("halt reset did not start stabilisation");
  AST_STAB_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_wake |=> cur.cnt == $past(stab_len))
    else $error("stabilisation length not loaded");
  AST_STAB_END: assert property (@(posedge pclk) disable iff (!presetn)
    s_stab_done |=> mode == 3'h0 && cpu_clk_en &&
    (resume || reset_fetch))
    else $error("stabilisation end did not resume");
  AST_EARLY_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_RUN && !wait_instruction && !halt_dec &&
    !reset_request && cur.grace != 13'h0 && !cur.ctrl[0]
    |=> mode == 3'h3)
    else $error("early enable clear did not fall into halt");
  AST_HALT_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    cur.st == lpmc_pkg::LPMC_RUN && opcode_valid &&
    opcode != lpmc_pkg::HALT_OPCODE && !wait_instruction &&
    !reset_request && cur.grace == 13'h0
    |=> mode == 3'h0 && !wdg_reset)
    else $error("other opcode treated as halt");
  AST_PORT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && pwrite &&
    paddr == lpmc_pkg::ADDR_PORT_VAL
    |=> pin_out == $past(pwdata[7:0]))
    else $error("port value write lost");
  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
endmodule : lpmc_top

// [dv/lpmc_partner.sv]
/*
 Far-side stand-in: CPU decode pulses and interrupt request latches.
 Assumes the bench pulses its command inputs for one pclk cycle.
*/
`timescale 1ns/100ps
module lpmc_partner (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Bench commands
  input logic do_wait,
  input logic do_halt,
  input logic [9:0] irq_set,
  // Controller side
  input logic resume,
  output logic wait_instruction,
  output logic opcode_valid,
  output logic [7:0] opcode,
  output logic [9:0] irq_pending
);
  // Idle bus shows a non-halt byte, never a stale halt code
  assign opcode = opcode_valid ? lpmc_pkg::HALT_OPCODE
                               : ~lpmc_pkg::HALT_OPCODE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_instruction <= 1'b0;
      opcode_valid <= 1'b0;
      irq_pending <= 10'h000;
    end else begin
      wait_instruction <= do_wait;
      opcode_valid <= do_halt;
      // Crude: one vector fetch clears every latch
      irq_pending <= resume ? irq_set : (irq_pending | irq_set);
    end
  end
endmodule : lpmc_partner

// [dv/tb.sv]
/*
 Bench for lpmc_top: table of mode cases, then hand-written cases.
 Assumes lpmc_partner stands in for CPU decode and interrupt latches.
*/
`timescale 1ns/100ps
module tb;
  localparam int SS = lpmc_pkg::STAB_SHORT;
  localparam int SL = lpmc_pkg::STAB_LONG;
  typedef struct packed {
    logic [3:0] ctrl;
    logic halt;
    logic wdg;
    logic [9:0] irq;
    logic [2:0] mode;
    logic [12:0] dly;
  } lpmc_row_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic do_wait, do_halt, wait_instruction, opcode_valid, resume;
  logic reset_request, watchdog_enabled, wdg_reset, reset_fetch;
  logic cpu_clk_en, periph_clk_en, osc_en, slow_wait, force_mask;
  logic [1:0] forced_mask_value;
  logic [2:0] mode;
  logic [7:0] opcode, pin_in, pin_out, pin_oe, pin_irq;
  logic [9:0] irq_set, irq_pending;
  int n_mismatch = 0;
  int n_tests = 0;
  int k, n_wdg = 0;
  lpmc_row_t rows [6];
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (wdg_reset === 1'b1) n_wdg++;
  lpmc_top DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wait_instruction, .opcode,
    .opcode_valid, .irq_pending, .reset_request, .watchdog_enabled,
    .condition_code_mask(2'b00), .cpu_clk_en, .periph_clk_en,
    .osc_en, .slow_wait, .force_mask, .forced_mask_value,
    .wdg_reset, .resume, .reset_fetch, .mode, .pin_in, .pin_out,
    .pin_oe, .pin_irq
  );
  lpmc_partner partner (
    .pclk, .presetn, .do_wait, .do_halt, .irq_set, .resume,
    .wait_instruction, .opcode_valid, .opcode, .irq_pending
  );
  task automatic chk(input string nm, input logic [31:0] x, y);
    n_tests++;
    if (y !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 50) begin
      t++;
      @(posedge pclk);
    end
    if (t >= 50) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic enter(input logic h, input int n);
    do_wait <= !h;
    do_halt <= h;
    @(posedge pclk);
    do_wait <= 1'b0;
    do_halt <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : enter
  task automatic pulse_irq(input logic [9:0] s);
    irq_set <= s;
    @(posedge pclk);
    irq_set <= 10'h000;
  endtask : pulse_irq
  task automatic outs(input logic [2:0] m, input logic sl);
    chk("mode", m, mode);
    chk("cpu_clk", m == 3'h0, cpu_clk_en);
    chk("periph_clk", m < 3'h2, periph_clk_en);
    chk("osc", m != 3'h3, osc_en);
    chk("mask_force", m inside {1, 2, 3}, force_mask);
    chk("slow_wait", m == 3'h1 && sl, slow_wait);
  endtask : outs
  // Sleep exits only after the stabilisation count, if one applies
  task automatic count_to(input logic rf, input int lo);
    k = 0;
    while ((rf ? reset_fetch : resume) !== 1'b1 && k < 5000) begin
      k++;
      @(posedge pclk);
    end
    chk("wake_delay", 1, k >= lo && k <= lo + 8);
  endtask : count_to
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, do_wait, do_halt} = 5'h00;
    {reset_request, watchdog_enabled} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_set = 10'h000;
    pin_in = 8'hff;
    rows = '{'{4'h0, 1'b0, 1'b0, 10'h040, 3'h1, 13'h0},
             '{4'h2, 1'b0, 1'b0, 10'h100, 3'h1, 13'h0},
             '{4'h1, 1'b1, 1'b1, 10'h001, 3'h2, 13'h0},
             '{4'h1, 1'b1, 1'b0, 10'h020, 3'h2, 13'h0},
             '{4'h0, 1'b1, 1'b0, 10'h002, 3'h3, 13'(SS)},
             '{4'hc, 1'b1, 1'b0, 10'h010, 3'h3, 13'(SL)}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    outs(3'h0, 1'b0);
    apb(1'b0, lpmc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_reset", lpmc_pkg::CTRL_RESET, q);
    foreach (rows[i]) begin
      apb(1'b1, lpmc_pkg::ADDR_CTRL, {28'h0, rows[i].ctrl});
      watchdog_enabled <= rows[i].wdg;
      enter(rows[i].halt, 4);
      outs(rows[i].mode, rows[i].ctrl[1]);
      chk("mask_val", lpmc_pkg::MASK_WAKE, forced_mask_value);
      pulse_irq(rows[i].irq);
      count_to(1'b0, rows[i].dly);
      @(posedge pclk);
      chk("mode_back", 3'h0, mode);
      // Let the grace window lapse so the next row's clear is legal
      if (rows[i].mode == 3'h2) repeat (SS + 4) @(posedge pclk);
    end
    chk("no_wdg_reset", 0, n_wdg);
    // Clearing the enable inside the grace window falls into halt
    apb(1'b1, lpmc_pkg::ADDR_CTRL, 32'h1);
    enter(1'b1, 4);
    pulse_irq(10'h001);
    count_to(1'b0, 0);
    apb(1'b1, lpmc_pkg::ADDR_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    chk("early_clear", 3'h3, mode);
    pulse_irq(10'h002);
    count_to(1'b0, SS - 8);
    apb(1'b1, lpmc_pkg::ADDR_CTRL, 32'h0);
    watchdog_enabled <= 1'b0;
    enter(1'b1, 4);
    pulse_irq(10'h3c0);
    repeat (8) @(posedge pclk);
    chk("no_wake", 3'h3, mode);
    pulse_irq(10'h008);
    count_to(1'b0, SS);
    apb(1'b1, lpmc_pkg::ADDR_CTRL, 32'h1);
    pulse_irq(10'h001);
    enter(1'b1, 0);
    count_to(1'b0, 0);
    enter(1'b1, 4);
    reset_request <= 1'b1;
    count_to(1'b1, SS);
    reset_request <= 1'b0;
    apb(1'b1, lpmc_pkg::ADDR_CTRL, 32'h8);
    watchdog_enabled <= 1'b1;
    k = n_wdg;
    enter(1'b1, 4);
    chk("wdg_reset", k + 1, n_wdg);
    chk("no_halt", 3'h0, mode);
    watchdog_enabled <= 1'b0;
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("slverr", 1, e);
    apb(1'b0, lpmc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_kept", 32'h8, q);
    // Software sets wake pin to input with interrupt before wait
    apb(1'b1, lpmc_pkg::ADDR_PORT_DIR, 32'h0f);
    apb(1'b1, lpmc_pkg::ADDR_PORT_VAL, 32'ha5);
    apb(1'b1, lpmc_pkg::ADDR_PORT_OPT, 32'h80);
    chk("pin_out", 8'ha5, pin_out);
    chk("pin_oe", 8'h0f, pin_oe);
    pin_in <= 8'h7f;
    q = 32'h0;
    repeat (4) begin
      @(posedge pclk);
      q[7:0] = q[7:0] | pin_irq;
    end
    chk("pin_irq", 8'h80, q);
    enter(1'b0, 4);
    presetn <= 1'b0;
    @(posedge pclk);
    outs(3'h0, 1'b0);
    tally_and_finish();
  end
  initial begin
    #60000;
    n_mismatch++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
endmodule : tb
